// [rtl/rsc_pkg.sv]
// constants for the reset source controller: map, fields, timing
// assumes one 200 MHz peripheral clock and an 8-bit register port
package rsc_pkg;

  // register map (byte offsets)
  localparam logic [7:0] RSC_OFF_FLAGS = 8'h00;
  localparam logic [7:0] RSC_OFF_SWREQ = 8'h01;

  // reset_cause_flags field positions
  localparam int RSC_POWER_ON_FLAG_BIT = 0;
  localparam int RSC_BROWNOUT_FLAG_BIT = 1;
  localparam int RSC_PIN_FLAG_BIT = 2;
  localparam int RSC_WATCHDOG_FLAG_BIT = 3;
  localparam int RSC_SOFTWARE_FLAG_BIT = 4;
  localparam int RSC_DEBUGGER_FLAG_BIT = 5;
  localparam int RSC_NUM_SRC = 6;
  localparam logic [7:0] RSC_FLAGS_USED = 8'h3f;

  // software_reset_request field
  localparam int RSC_SW_TRIGGER_BIT = 0;
  localparam logic [7:0] RSC_SWREQ_READ = 8'h00;

  // reset values
  localparam logic [7:0] RSC_FLAGS_RESET = 8'h01;
  localparam logic [4:0] RSC_SYNC_RESET = 5'h05;

  // change_protection: key value is arbitrary
  localparam logic [7:0] RSC_IO_REGISTER_KEY = 8'h5a;
  localparam logic [2:0] RSC_CCP_WINDOW = 3'h4;

  // timing, printed units and derived cycle counts
  localparam int RSC_CLK_MHZ = 200;
  localparam int RSC_INIT_US = 250;
  localparam int RSC_CHECK_US_PER_KB = 500;
  localparam int RSC_SUT_STEP_US = 1;
  localparam int RSC_INIT_CYCLES = RSC_INIT_US * RSC_CLK_MHZ;
  localparam int RSC_KB_CYCLES = RSC_CHECK_US_PER_KB * RSC_CLK_MHZ;
  localparam int RSC_SUT_STEP_CYCLES = RSC_SUT_STEP_US * RSC_CLK_MHZ;

  // brownout level forced when the detector is not used
  localparam logic [2:0] RSC_BOD_MIN_LEVEL = 3'h0;

  // sequencer states
  typedef enum logic [2:0] {
    RSC_RUN  = 3'b001,
    RSC_HOLD = 3'b010,
    RSC_INIT = 3'b100
  } rsc_state_t;

endpackage

// [rtl/rsc_reset_controller.sv]
// reset source controller: merges six reset sources, times the
// internal initialization and keeps the reset cause flags
// assumes detector, pin, watchdog and debugger levels are asynchronous,
// fuse inputs are static while power-on reset is applied
// Summary of operation
// - controller always on; only the pin source needs enabling
// - record cause flags when reset completes
// - power-on leaves only power-on flag set
// - flags clear only by writing one or by a completed power-on
// - fuse-loaded values reload during power-on
// - power-on detector always enabled, resets all
// - brownout resets all; fuse level, forced minimum
// - trigger bit write resets at once
// - software reset spares debug, timer fuses, brownout
// - pin low holds reset when fuse enabled
// - pin reset spares debug, overrides, brownout; here the timer fuse overrides are reset
// - watchdog timeout resets, same sparing as pin
// - debugger reset only from programmer, same sparing
// - init lasts 250 us plus start-up fuse
// - boot check adds 500 us per kilobyte
// - runs in active and every sleep mode
// - key then write within four instructions
// - bit 5 set by debugger reset
// - bit 4 set by software reset
// - bits 3..0 watchdog, pin, brownout, power-on
// - trigger bit always reads zero
// - after power-on, other flags wait for boot
//
// Implementation choice: strobed register access.
module rsc_reset_controller
  import rsc_pkg::*;
#(
  parameter int INIT_CYCLES = rsc_pkg::RSC_INIT_CYCLES,
  parameter int KB_CYCLES = rsc_pkg::RSC_KB_CYCLES,
  parameter int SUT_STEP_CYCLES = rsc_pkg::RSC_SUT_STEP_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // reset sources
  input wire logic POWER_ON_DETECT,
  input wire logic BROWNOUT_DETECT,
  input wire logic RESET_PIN_N,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic DEBUGGER_RESET_REQ,
  // fuses
  input wire logic PIN_RESET_FUSE_EN,
  input wire logic BROWNOUT_FUSE_EN,
  input wire logic [2:0] BROWNOUT_FUSE_LEVEL,
  input wire logic [2:0] STARTUP_TIME_FUSE,
  input wire logic BOOT_CHECK_SOURCE_EN,
  input wire logic [3:0] BOOT_CHECK_KB,
  // change_protection
  input wire logic KEY_WRITE,
  input wire logic [7:0] KEY_DATA,
  input wire logic INSTR_DONE,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // reset outputs
  output logic RESET_ALL,
  output logic RESET_CORE,
  output logic RESET_TIMER_FUSE,
  output logic FUSE_RELOAD,
  output logic INIT_BUSY,
  output logic BROWNOUT_ENABLE,
  output logic [2:0] BROWNOUT_LEVEL
);

  import rsc_pkg::*;

  // synchronised source levels
  logic [4:0] sync_lv;
  logic por_s;
  logic bod_s;
  logic pin_n_s;
  logic wdt_s;
  logic dbg_s;

  rsc_sync #(
    .WIDTH(5),
    .RST_VAL(RSC_SYNC_RESET)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RESETN),
    .async_in({DEBUGGER_RESET_REQ, WATCHDOG_TIMEOUT, RESET_PIN_N,
               BROWNOUT_DETECT, POWER_ON_DETECT}),
    .sync_out(sync_lv)
  );

  assign por_s = sync_lv[0];
  assign bod_s = sync_lv[1];
  assign pin_n_s = sync_lv[2];
  assign wdt_s = sync_lv[3];
  assign dbg_s = sync_lv[4];

  // fuse shadows, reloaded only during a power-on sequence
  logic pin_en_q;
  logic bod_en_q;
  logic [2:0] bod_lvl_q;
  logic [2:0] sut_q;
  logic chk_en_q;
  logic [3:0] chk_kb_q;

  // sequencer
  rsc_state_t state_q;
  rsc_state_t state_d;
  logic [RSC_NUM_SRC-1:0] seen_q;
  logic [RSC_NUM_SRC-1:0] req;
  logic [31:0] cnt_q;
  logic [31:0] init_len;
  logic boot_done_q;

  // change_protection window and software trigger
  logic [2:0] ccp_q;
  logic sw_hit;

  // flags
  logic [7:0] flags_q;
  logic [7:0] flags_set;
  logic [7:0] flags_clr;
  logic done;

  // strobe and address passed in so the decode follows them
  function automatic logic wr_at(input logic wr, input logic [7:0] a,
                                 input logic [7:0] off);
    wr_at = wr && (a == off);
  endfunction

  // the bus decode is used for both writes and key-guarded trigger
  assign sw_hit = wr_at(REG_WR, REG_ADDR, RSC_OFF_SWREQ) &&
                  (ccp_q != 3'h0) &&
                  REG_WDATA[RSC_SW_TRIGGER_BIT];

  // live requests; the pin source only counts once its fuse enable is sampled
  always_comb begin
    req = '0;
    req[RSC_POWER_ON_FLAG_BIT] = por_s;
    req[RSC_BROWNOUT_FLAG_BIT] = bod_s;
    req[RSC_PIN_FLAG_BIT] = pin_en_q && !pin_n_s;
    req[RSC_WATCHDOG_FLAG_BIT] = wdt_s;
    req[RSC_DEBUGGER_FLAG_BIT] = dbg_s;
    req[RSC_SOFTWARE_FLAG_BIT] = sw_hit;
  end

  // init length: base, start-up steps, optional boot check
  always_comb begin
    init_len = 32'(INIT_CYCLES) +
               32'(sut_q) * 32'(SUT_STEP_CYCLES);
    if (chk_en_q) begin
      init_len = init_len + 32'(chk_kb_q) * 32'(KB_CYCLES);
    end
  end

  // no sleep input: the sequencer never stops with the cpu
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSC_RUN: begin
        if (|req) begin
          state_d = RSC_HOLD;
        end
      end
      RSC_HOLD: begin
        if (!(|req)) begin
          state_d = RSC_INIT;
        end
      end
      RSC_INIT: begin
        if (|req) begin
          state_d = RSC_HOLD;
        end else if (cnt_q == 32'h0) begin
          state_d = RSC_RUN;
        end
      end
      default: begin
        state_d = RSC_HOLD;
      end
    endcase
  end

  assign done = (state_q == RSC_INIT) && !(|req) && (cnt_q == 32'h0);

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q <= RSC_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // sources seen during one reset episode
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      seen_q <= RSC_FLAGS_RESET[RSC_NUM_SRC-1:0];
    end else if (state_q == RSC_RUN) begin
      seen_q <= req;
    end else begin
      seen_q <= seen_q | req;
    end
  end

  // init counter, reloaded whenever a source is active
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cnt_q <= 32'h0;
    end else if (|req || state_q != RSC_INIT) begin
      cnt_q <= init_len - 32'h1;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  // full boot marker: cleared by power-on, set when it completes
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      boot_done_q <= 1'b0;
    end else if (req[RSC_POWER_ON_FLAG_BIT]) begin
      boot_done_q <= 1'b0;
    end else if (done) begin
      boot_done_q <= 1'b1;
    end
  end

  // fuse shadows follow the fuses while a power-on is in progress
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pin_en_q <= 1'b0;
      bod_en_q <= 1'b0;
      bod_lvl_q <= RSC_BOD_MIN_LEVEL;
      sut_q <= 3'h0;
      chk_en_q <= 1'b0;
      chk_kb_q <= 4'h0;
    end else if (state_q != RSC_RUN && seen_q[RSC_POWER_ON_FLAG_BIT]) begin
      pin_en_q <= PIN_RESET_FUSE_EN;
      bod_en_q <= BROWNOUT_FUSE_EN;
      bod_lvl_q <= BROWNOUT_FUSE_LEVEL;
      sut_q <= STARTUP_TIME_FUSE;
      chk_en_q <= BOOT_CHECK_SOURCE_EN;
      chk_kb_q <= BOOT_CHECK_KB;
    end
  end

  // key opens a four-instruction window; any reset closes it
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ccp_q <= 3'h0;
    end else if (state_q != RSC_RUN || sw_hit) begin
      ccp_q <= 3'h0;
    end else if (KEY_WRITE && KEY_DATA == RSC_IO_REGISTER_KEY) begin
      ccp_q <= RSC_CCP_WINDOW;
    end else if (INSTR_DONE && ccp_q != 3'h0) begin
      ccp_q <= ccp_q - 3'h1;
    end
  end

  // cause flags are recorded at the end of the episode
  always_comb begin
    flags_set = 8'h00;
    if (done) begin
      if (seen_q[RSC_POWER_ON_FLAG_BIT]) begin
        flags_set[RSC_POWER_ON_FLAG_BIT] = 1'b1;
      end else if (boot_done_q) begin
        flags_set[RSC_NUM_SRC-1:0] = seen_q;
      end
    end
  end

  assign flags_clr = wr_at(REG_WR, REG_ADDR, RSC_OFF_FLAGS) ?
                     REG_WDATA : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      flags_q <= RSC_FLAGS_RESET;
    end else if (done && seen_q[RSC_POWER_ON_FLAG_BIT]) begin
      flags_q <= flags_set;
    end else begin
      // a new cause wins over a clear in the same cycle
      flags_q <= (flags_set | (flags_q & ~flags_clr)) &
                 RSC_FLAGS_USED;
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        RSC_OFF_FLAGS: REG_RDATA <= flags_q & RSC_FLAGS_USED;
        RSC_OFF_SWREQ: REG_RDATA <= RSC_SWREQ_READ;
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // reset domains; power resets reach everything, others spare
  // the debug interface and brownout setup, and software reset also the timer pin overrides
  logic in_rst_d;
  logic pwr_d;
  logic tfuse_d;

  assign in_rst_d = (state_d != RSC_RUN);
  assign pwr_d = in_rst_d &&
                 (|((seen_q | req) & 6'h03));
  // software reset alone spares the timer fuse configuration
  assign tfuse_d = in_rst_d &&
                   (|((seen_q | req) & 6'h2f));

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RESET_ALL <= 1'b1;
      RESET_CORE <= 1'b1;
      RESET_TIMER_FUSE <= 1'b1;
    end else begin
      RESET_ALL <= pwr_d;
      RESET_CORE <= in_rst_d;
      RESET_TIMER_FUSE <= tfuse_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      FUSE_RELOAD <= 1'b1;
      INIT_BUSY <= 1'b0;
    end else begin
      FUSE_RELOAD <= in_rst_d &&
                     (seen_q[RSC_POWER_ON_FLAG_BIT] || por_s);
      INIT_BUSY <= (state_d == RSC_INIT);
    end
  end

  // detector stays on at the minimum level when the fuse leaves it off
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      BROWNOUT_ENABLE <= 1'b1;
      BROWNOUT_LEVEL <= RSC_BOD_MIN_LEVEL;
    end else begin
      BROWNOUT_ENABLE <= 1'b1;
      BROWNOUT_LEVEL <= bod_en_q ? bod_lvl_q : RSC_BOD_MIN_LEVEL;
    end
  end

endmodule

// [rtl/rsc_sync.sv]
// three-stage synchroniser with agreement filter for pin-side levels
// assumes the inputs are asynchronous to CLOCK
module rsc_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync_out[g] <= RST_VAL[g];
        end else if (s2_q[g] == s3_q[g]) begin
          sync_out[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule

// [tb/rsc_asserts.sv]
// port assertions for the reset source controller
// assumes one clock, RESETN synchronous active low
module rsc_asserts
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // sources and key
  input wire logic RESET_PIN_N,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic PIN_RESET_FUSE_EN,
  input wire logic KEY_WRITE,
  input wire logic [7:0] KEY_DATA,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // reset outputs
  input wire logic RESET_ALL,
  input wire logic RESET_CORE,
  input wire logic RESET_TIMER_FUSE,
  input wire logic INIT_BUSY,
  input wire logic BROWNOUT_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  bod_on_a: assert property (BROWNOUT_ENABLE)
    else $error("brownout detector off");
  all_core_a: assert property (RESET_ALL |-> RESET_CORE)
    else $error("full reset without core reset");
  timer_core_a: assert property (
    RESET_TIMER_FUSE |-> RESET_CORE)
    else $error("timer reset outside episode");
  init_held_a: assert property (INIT_BUSY |-> RESET_CORE)
    else $error("init while released");
  release_init_a: assert property (
    $fell(RESET_CORE) |-> $past(INIT_BUSY))
    else $error("release without init");
  wdt_hold_a: assert property (
    WATCHDOG_TIMEOUT [*8] |-> RESET_CORE && !INIT_BUSY)
    else $error("watchdog not holding reset");
  pin_hold_a: assert property (
    (PIN_RESET_FUSE_EN && !RESET_PIN_N) [*8] |-> RESET_CORE)
    else $error("pin not holding reset");
  sw_trigger_a: assert property (
    KEY_WRITE && KEY_DATA == RSC_IO_REGISTER_KEY && !RESET_CORE
    ##1 REG_WR && REG_ADDR == RSC_OFF_SWREQ && REG_WDATA[0]
    |-> ##[1:2] RESET_CORE)
    else $error("keyed trigger ignored");
  swreq_zero_a: assert property (
    $past(REG_RD) && $past(REG_ADDR) == RSC_OFF_SWREQ
    |-> REG_RDATA == RSC_SWREQ_READ)
    else $error("trigger bit read nonzero");
  flag_top_a: assert property (
    $past(REG_RD) && $past(REG_ADDR) == RSC_OFF_FLAGS
    |-> REG_RDATA[7:6] == 2'h0)
    else $error("flag bits 7:6 nonzero");
endmodule

bind rsc_reset_controller rsc_asserts chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .RESET_PIN_N(RESET_PIN_N),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
  .PIN_RESET_FUSE_EN(PIN_RESET_FUSE_EN),
  .KEY_WRITE(KEY_WRITE), .KEY_DATA(KEY_DATA),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RESET_ALL(RESET_ALL),
  .RESET_CORE(RESET_CORE), .RESET_TIMER_FUSE(RESET_TIMER_FUSE),
  .INIT_BUSY(INIT_BUSY), .BROWNOUT_ENABLE(BROWNOUT_ENABLE)
);

// [tb/rsc_sources.sv]
// behavioural reset sources: supply detectors, pin, watchdog, debugger
// assumes kick is called just after a rising clk edge
module rsc_sources (
  // clock
  input wire logic clk,
  // source levels
  output logic por_det,
  output logic bod_det,
  output logic pin_n,
  output logic wdt_to,
  output logic dbg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  int left [5] = '{default: 0};
  logic [4:0] lvl_q = 5'h00;
  // levels only; no pulse shorter than the sync filter
  task kick(input int i, input int n);
    left[i] = n;
  endtask
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      lvl_q[i] <= (left[i] > 0);
      if (left[i] > 0) begin
        left[i] = left[i] - 1;
      end
    end
  end
  assign por_det = lvl_q[0];
  assign bod_det = lvl_q[1];
  assign pin_n = !lvl_q[2];
  assign wdt_to = lvl_q[3];
  // only this model ever raises the debugger request
  assign dbg_req = lvl_q[4];
endmodule

// [tb/test_rsc_reset_controller.sv]
// bench for the reset source controller: sources, flags, key window
// assumes rsc_sources drives the source levels, fuses move only
// ahead of a power-on
`define CHK(nm, ex, ac) begin total_checks++; \
  if ((ac) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module test_rsc_reset_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  // short counts; start-up fuse 3 steps, check of 2 kilobytes
  localparam int BOOT_N = 20 + 3 * 2 + 2 * 10;
  // later fuses: start-up 1 step, no boot check
  localparam int FUSE_N = 20 + 1 * 2;
  logic clk = 0, rst_n = 0, pin_fuse = 0, key_wr = 0, instr = 0;
  logic wr_s = 0, rd_s = 0;
  logic [7:0] key = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
  logic por, brownout_detector, pin_n, wdt, dbg, r_all, r_core, r_tf, reload, busy;
  logic bod_en, bod_fuse = 1, chk_fuse = 1;
  logic [2:0] bod_lvl;
  logic [2:0] startup_time_fuse = 3'h3;
  int fail_count = 0, total_checks = 0, nb;
  rsc_sources src (.clk(clk), .por_det(por), .bod_det(brownout_detector),
    .pin_n(pin_n), .wdt_to(wdt), .dbg_req(dbg));
  rsc_reset_controller #(.INIT_CYCLES(20), .KB_CYCLES(10),
    .SUT_STEP_CYCLES(2)) dut (.CLOCK(clk), .RESETN(rst_n),
    .POWER_ON_DETECT(por), .BROWNOUT_DETECT(brownout_detector), .RESET_PIN_N(pin_n),
    .WATCHDOG_TIMEOUT(wdt), .DEBUGGER_RESET_REQ(dbg),
    .PIN_RESET_FUSE_EN(pin_fuse), .BROWNOUT_FUSE_EN(bod_fuse),
    .BROWNOUT_FUSE_LEVEL(3'h5), .STARTUP_TIME_FUSE(startup_time_fuse),
    .BOOT_CHECK_SOURCE_EN(chk_fuse), .BOOT_CHECK_KB(4'h2),
    .KEY_WRITE(key_wr), .KEY_DATA(key), .INSTR_DONE(instr),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .RESET_ALL(r_all), .RESET_CORE(r_core),
    .RESET_TIMER_FUSE(r_tf), .FUSE_RELOAD(reload), .INIT_BUSY(busy),
    .BROWNOUT_ENABLE(bod_en), .BROWNOUT_LEVEL(bod_lvl));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task wrap_up();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 `CHK("read data", e, rdata)
  endtask
  // bounded wait; counts init cycles seen meanwhile
  task wait_core(input logic v);
    int n;
    n = 0;
    nb = 0;
    while (r_core !== v && n < 400) begin
      @(posedge clk);
      #1 n++;
      nb += (busy === 1'b1);
    end
    `CHK("reset level", v, r_core)
  endtask
  task t_regs();
    rd(RSC_OFF_FLAGS, 8'h01);
    wr(RSC_OFF_FLAGS, 8'h00);
    rd(RSC_OFF_FLAGS, 8'h01);
    wr(RSC_OFF_FLAGS, 8'hc0);
    rd(RSC_OFF_FLAGS, 8'h01);
    wr(RSC_OFF_FLAGS, 8'h01);
    rd(RSC_OFF_FLAGS, 8'h00);
    rd(RSC_OFF_SWREQ, 8'h00);
    rd(8'h02, 8'h00);
    `CHK("bod on", 1'b1, bod_en)
  endtask
  // pin fuse not yet sampled on: pin low is ignored
  task t_pin_off();
    src.kick(2, 20);
    repeat (24) @(posedge clk);
    #1 `CHK("pin off", 1'b0, r_core)
    pin_fuse <= 1'b1;
  endtask
  task t_src(input int i);
    logic [7:0] f;
    f = (i == 4) ? 8'h20 : 8'h01 << i;
    wr(RSC_OFF_FLAGS, 8'h3f);
    src.kick(i, 40);
    wait_core(1'b1);
    repeat (30) @(posedge clk);
    #1 `CHK("held", 1'b0, busy)
    `CHK("full", i < 2, r_all)
    `CHK("timer", 1'b1, r_tf)
    `CHK("reload", i == 0, reload)
    wait_core(1'b0);
    `CHK("init", BOOT_N, nb)
    rd(RSC_OFF_FLAGS, f);
  endtask
  task sw_try(input logic [7:0] k, input int n, input logic e);
    @(posedge clk);
    key_wr <= 1'b1;
    key <= k;
    repeat (n) begin
      @(posedge clk);
      key_wr <= 1'b0;
      instr <= 1'b1;
      @(posedge clk);
      instr <= 1'b0;
    end
    @(posedge clk);
    key_wr <= 1'b0;
    addr <= RSC_OFF_SWREQ;
    wdata <= 8'h01;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    // looked at on the strobe's edge so no init cycle is missed
    #1 `CHK("sw reset", e, r_core)
    if (e) `CHK("sw timer", 1'b0, r_tf)
  endtask
  task t_sw();
    wr(RSC_OFF_FLAGS, 8'h3f);
    sw_try(~RSC_IO_REGISTER_KEY, 0, 1'b0);
    sw_try(RSC_IO_REGISTER_KEY, 4, 1'b0);
    sw_try(RSC_IO_REGISTER_KEY, 0, 1'b1);
    wait_core(1'b0);
    `CHK("sw init", BOOT_N, nb)
    rd(RSC_OFF_FLAGS, 8'h10);
  endtask
  // new fuses reach the shadows only through a power-on
  task t_fuse();
    bod_fuse <= 1'b0;
    chk_fuse <= 1'b0;
    startup_time_fuse <= 3'h1;
    src.kick(0, 40);
    src.kick(3, 40);
    wait_core(1'b1);
    wait_core(1'b0);
    `CHK("fuse init", FUSE_N, nb)
    `CHK("bod min", RSC_BOD_MIN_LEVEL, bod_lvl)
    rd(RSC_OFF_FLAGS, 8'h01);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_core(1'b0);
    t_regs();
    t_pin_off();
    for (int i = 0; i < 5; i++) begin
      t_src(i);
    end
    `CHK("bod level", 3'h5, bod_lvl)
    t_sw();
    t_fuse();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
